//--- picctl_host.sv
// host controller for the eight-level interrupt controller: command port,
// init tracking and the acknowledge sequence that collects the vector
// assumes device pins synchronous to REF_CLK and a pull-up on the data bus
//
// Summary of operation
// - read and write strobes count only with select low; acknowledge strobes run deselected
// - host writes words with select and address
// - call mode host adds two more pulses
// - init of two to four words first
`timescale 1ns/100ps
`default_nettype none
module picctl_host (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // user command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_ADDR,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  output logic CMD_REFUSED,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic INIT_DONE,
  // vector delivery
  input wire logic ACK_ENABLE,
  output logic VEC_VALID,
  output logic VEC_POINTER_MODE,
  output logic [7:0] VEC_OPCODE,
  output logic [15:0] VEC_ADDR,
  // device pins
  output logic PIC_CS_N,
  output logic PIC_WR_N,
  output logic PIC_RD_N,
  output logic PIC_CPU_ACK_N,
  output logic PIC_CMD_ADDR_BIT,
  input wire logic [7:0] PIC_D_IN,
  output logic [7:0] PIC_D_OUT,
  output logic PIC_D_OE,
  input wire logic PIC_INT
);
  import picctl_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'h1, M_BUS = 3'h2, M_ACK = 3'h4
  } picctl_mst_e;

  picctl_cyc_if cyc ();

  picctl_mst_e state_reg, state_next;
  logic req_reg, req_next, addr_reg, addr_next;
  picctl_kind_e kind_reg, kind_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [2:0] step_reg, step_next;
  logic init_done_reg, init_done_next, sngl_reg, sngl_next, ic4_reg, ic4_next, pmode_reg, pmode_next;
  logic [1:0] ack_cnt_reg, ack_cnt_next;
  logic [7:0] byte_reg [0:2];
  logic [7:0] byte_next [0:2];
  logic ready_reg, ready_next, refused_reg, refused_next, rd_valid_reg, rd_valid_next;
  logic [7:0] rd_data_reg, rd_data_next, vec_op_reg, vec_op_next;
  logic vec_valid_reg, vec_valid_next;
  logic [15:0] vec_addr_reg, vec_addr_next;
  logic is_icw1, cmd_ok;
  logic [2:0] step_after;

  // first init word is recognised on any address-zero write with the init bit set, restarting the sequence
  assign is_icw1 = CMD_WRITE && !CMD_ADDR && CMD_DATA[ICW1_INIT_BIT];
  // reads need finished init; stray writes before any first word are refused
  assign cmd_ok = CMD_WRITE ? (is_icw1 || init_done_reg || step_reg != STEP_NONE) : init_done_reg;

  // which init word follows the current one
  always_comb begin
    step_after = STEP_NONE;
    unique case (step_reg)
      STEP_ICW2: step_after = !sngl_reg ? STEP_ICW3 : (ic4_reg ? STEP_ICW4 : STEP_NONE);
      STEP_ICW3: step_after = ic4_reg ? STEP_ICW4 : STEP_NONE;
      default: step_after = STEP_NONE;
    endcase
  end

  // sequencer next values
  always_comb begin
    state_next = state_reg;
    req_next = 1'b0;
    kind_next = kind_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    step_next = step_reg;
    init_done_next = init_done_reg;
    sngl_next = sngl_reg;
    ic4_next = ic4_reg;
    pmode_next = pmode_reg;
    ack_cnt_next = ack_cnt_reg;
    byte_next = byte_reg;
    refused_next = 1'b0;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    vec_valid_next = 1'b0;
    vec_op_next = vec_op_reg;
    vec_addr_next = vec_addr_reg;
    unique case (state_reg)
      M_IDLE: begin
        // user commands win over a pending acknowledge, keeping the handshake honest
        if (CMD_VALID && !cmd_ok) begin
          refused_next = 1'b1;
        end else if (CMD_VALID) begin
          req_next = 1'b1;
          kind_next = CMD_WRITE ? PICCTL_WR : PICCTL_RD;
          addr_next = CMD_ADDR;
          wdata_next = CMD_DATA;
          state_next = M_BUS;
          if (is_icw1) begin
            // a missing fourth word means its functions are zero
            sngl_next = CMD_DATA[ICW1_SNGL_BIT];
            ic4_next = CMD_DATA[ICW1_IC4_BIT];
            pmode_next = 1'b0;
            step_next = STEP_ICW2;
            init_done_next = 1'b0;
          end else if (CMD_WRITE && step_reg != STEP_NONE) begin
            if (step_reg == STEP_ICW4) begin
              pmode_next = CMD_DATA[ICW4_UPM_BIT];
            end
            step_next = step_after;
            init_done_next = (step_after == STEP_NONE);
          end
        end else if (PIC_INT && ACK_ENABLE && init_done_reg) begin
          req_next = 1'b1;
          kind_next = PICCTL_ACK;
          ack_cnt_next = 2'h1;
          state_next = M_ACK;
        end
      end
      M_BUS: begin
        if (cyc.done) begin
          rd_valid_next = (kind_reg == PICCTL_RD);
          rd_data_next = (kind_reg == PICCTL_RD) ? cyc.rdata : rd_data_reg;
          state_next = M_IDLE;
        end
      end
      M_ACK: begin
        if (cyc.done) begin
          byte_next[2'(ack_cnt_reg - 2'h1)] = cyc.rdata;
          if (ack_cnt_reg == (pmode_reg ? PTR_PULSES : CALL_PULSES)) begin
            vec_valid_next = 1'b1;
            // pointer mode first byte is floated bus, not reported
            vec_op_next = pmode_reg ? 8'h00 : byte_reg[0];
            vec_addr_next = pmode_reg ? {8'h00, cyc.rdata} : {cyc.rdata, byte_reg[1]};
            state_next = M_IDLE;
          end else begin
            // the whole sequence runs even if the interrupt drops meanwhile
            ack_cnt_next = ack_cnt_reg + 2'h1;
            req_next = 1'b1;
          end
        end
      end
    endcase
    ready_next = (state_next == M_IDLE) && !(state_reg == M_IDLE && CMD_VALID);
  end

  // sequencer registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= M_IDLE;
      req_reg <= 1'b0;
      kind_reg <= PICCTL_WR;
      addr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      step_reg <= STEP_NONE;
      init_done_reg <= 1'b0;
      sngl_reg <= 1'b0;
      ic4_reg <= 1'b0;
      pmode_reg <= 1'b0;
      ack_cnt_reg <= 2'h0;
      byte_reg <= '{8'h00, 8'h00, 8'h00};
      ready_reg <= 1'b0;
      refused_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      vec_valid_reg <= 1'b0;
      vec_op_reg <= 8'h00;
      vec_addr_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      kind_reg <= kind_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      step_reg <= step_next;
      init_done_reg <= init_done_next;
      sngl_reg <= sngl_next;
      ic4_reg <= ic4_next;
      pmode_reg <= pmode_next;
      ack_cnt_reg <= ack_cnt_next;
      byte_reg <= byte_next;
      ready_reg <= ready_next;
      refused_reg <= refused_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      vec_valid_reg <= vec_valid_next;
      vec_op_reg <= vec_op_next;
      vec_addr_reg <= vec_addr_next;
    end
  end

  // request to the strobe engine
  assign cyc.req = req_reg;
  assign cyc.kind = kind_reg;
  assign cyc.addr = addr_reg;
  assign cyc.wdata = wdata_reg;

  picctl_strobe u_strobe (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .cyc(cyc),
    .cs_n(PIC_CS_N),
    .wr_n(PIC_WR_N),
    .rd_n(PIC_RD_N),
    .ack_n(PIC_CPU_ACK_N),
    .a0(PIC_CMD_ADDR_BIT),
    .d_in(PIC_D_IN),
    .d_out(PIC_D_OUT),
    .d_oe(PIC_D_OE)
  );

  // user outputs from flops
  assign CMD_READY = ready_reg;
  assign CMD_REFUSED = refused_reg;
  assign RD_VALID = rd_valid_reg;
  assign RD_DATA = rd_data_reg;
  assign INIT_DONE = init_done_reg;
  assign VEC_VALID = vec_valid_reg;
  assign VEC_POINTER_MODE = pmode_reg;
  assign VEC_OPCODE = vec_op_reg;
  assign VEC_ADDR = vec_addr_reg;

  // acknowledge pulses seen in the current sequence, for checking only
  // falling edge found from a registered copy, so no sampled-value call here
  logic [2:0] pulses_reg, pulses_next;
  logic ack_prev_reg, ack_prev_next;
  always_comb begin
    pulses_next = pulses_reg;
    ack_prev_next = PIC_CPU_ACK_N;
    if (state_reg == M_IDLE) begin
      pulses_next = 3'h0;
    end else if (ack_prev_reg && !PIC_CPU_ACK_N) begin
      pulses_next = pulses_reg + 3'h1;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pulses_reg <= 3'h0;
      ack_prev_reg <= 1'b1;
    end else begin
      pulses_reg <= pulses_next;
      ack_prev_reg <= ack_prev_next;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_ack_after_init: assert property ($rose(state_reg == M_ACK) |-> init_done_reg) else $error("ack before init");
  a_call_three_pulses: assert property (VEC_VALID && !pmode_reg |-> pulses_reg == 3'h3) else $error("call mode pulse count");
  a_ptr_two_pulses: assert property (VEC_VALID && pmode_reg |-> pulses_reg == 3'h2) else $error("pointer mode pulse count");
  a_icw1_restarts: assert property (CMD_VALID && state_reg == M_IDLE && is_icw1 |=> !init_done_reg && step_reg == STEP_ICW2)
    else $error("first init word not restarting");
  a_early_read_refused: assert property (CMD_VALID && !CMD_WRITE && state_reg == M_IDLE && !init_done_reg |=> CMD_REFUSED && !PIC_CS_N == 1'b0)
    else $error("read before init not refused");
  a_vector_bounded: assert property ($rose(state_reg == M_ACK) |-> ##[1:200] VEC_VALID) else $error("vector never delivered");

  c_write_done: cover property (state_reg == M_BUS && kind_reg == PICCTL_WR && cyc.done);
  c_read_done: cover property (RD_VALID);
  c_call_vector: cover property (VEC_VALID && !pmode_reg);
  c_ptr_vector: cover property (VEC_VALID && pmode_reg);
endmodule // picctl_host
`default_nettype wire

//--- picctl_pkg.sv
// constants, codes and timing for the interrupt controller host
// assumes a 200 MHz reference clock and pins synchronous to it
package picctl_pkg;
  // clock and strobe timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_PULSE_NS = 30;
  localparam int T_RECOV_NS = 20;
  // least times round up to whole cycles
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOV_CYC = 4'((T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // first init word fields
  localparam int ICW1_INIT_BIT = 4;
  localparam int ICW1_SNGL_BIT = 1;
  localparam int ICW1_IC4_BIT = 0;
  // fourth init word: processor family select
  localparam int ICW4_UPM_BIT = 0;
  // acknowledge pulse counts per processor family
  localparam logic [1:0] CALL_PULSES = 2'h3;
  localparam logic [1:0] PTR_PULSES = 2'h2;
  // init word expected next
  localparam logic [2:0] STEP_NONE = 3'h0;
  localparam logic [2:0] STEP_ICW2 = 3'h2;
  localparam logic [2:0] STEP_ICW3 = 3'h3;
  localparam logic [2:0] STEP_ICW4 = 3'h4;
  // bus cycle kinds
  typedef enum logic [1:0] {
    PICCTL_WR = 2'h0,
    PICCTL_RD = 2'h1,
    PICCTL_ACK = 2'h2
  } picctl_kind_e;
endpackage

//--- picctl_cyc_if.sv
// one bus cycle request between the host sequencer and the strobe engine
// assumes both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface picctl_cyc_if;
  import picctl_pkg::*;
  logic req;
  picctl_kind_e kind;
  logic addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy;
  logic done;
  modport master (output req, kind, addr, wdata, input rdata, busy, done);
  modport seq (input req, kind, addr, wdata, output rdata, busy, done);
endinterface
`default_nettype wire

//--- picctl_strobe.sv
// strobe engine: runs one write, read or acknowledge cycle on the pins
// assumes the device pins are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module picctl_strobe (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cycle request
  picctl_cyc_if.seq cyc,
  // device pins
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic ack_n,
  output logic a0,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe
);
  import picctl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_SETUP = 4'h2, S_PULSE = 4'h4, S_RECOV = 4'h8
  } picctl_sst_e;

  picctl_sst_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  picctl_kind_e kind_reg, kind_next;
  logic cs_n_reg, cs_n_next, wr_n_reg, wr_n_next, rd_n_reg, rd_n_next, ack_n_reg, ack_n_next;
  logic a0_reg, a0_next, d_oe_reg, d_oe_next, done_reg, done_next;
  logic [7:0] d_out_reg, d_out_next, rdata_reg, rdata_next;

  // next values of the cycle sequence
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    kind_next = kind_reg;
    cs_n_next = cs_n_reg;
    wr_n_next = wr_n_reg;
    rd_n_next = rd_n_reg;
    ack_n_next = ack_n_reg;
    a0_next = a0_reg;
    d_oe_next = d_oe_reg;
    d_out_next = d_out_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    unique case (state_reg)
      S_IDLE: begin
        if (cyc.req) begin
          kind_next = cyc.kind;
          // select only for register cycles; acknowledge runs deselected
          cs_n_next = (cyc.kind == PICCTL_ACK);
          a0_next = cyc.addr;
          d_out_next = cyc.wdata;
          d_oe_next = (cyc.kind == PICCTL_WR);
          cnt_next = SETUP_CYC - 4'h1;
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        if (cnt_reg == 4'h0) begin
          wr_n_next = (kind_reg != PICCTL_WR);
          rd_n_next = (kind_reg != PICCTL_RD);
          ack_n_next = (kind_reg != PICCTL_ACK);
          cnt_next = PULSE_CYC - 4'h1;
          state_next = S_PULSE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      S_PULSE: begin
        if (cnt_reg == 4'h0) begin
          // sample just before the rising edge while the device still drives
          if (kind_reg != PICCTL_WR) begin
            rdata_next = d_in;
          end
          wr_n_next = 1'b1;
          rd_n_next = 1'b1;
          ack_n_next = 1'b1;
          cnt_next = RECOV_CYC - 4'h1;
          state_next = S_RECOV;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      S_RECOV: begin
        // select and data held through recovery for hold time
        if (cnt_reg == 4'h0) begin
          cs_n_next = 1'b1;
          d_oe_next = 1'b0;
          done_next = 1'b1;
          state_next = S_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      kind_reg <= PICCTL_WR;
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      ack_n_reg <= 1'b1;
      a0_reg <= 1'b0;
      d_oe_reg <= 1'b0;
      d_out_reg <= 8'h00;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      cs_n_reg <= cs_n_next;
      wr_n_reg <= wr_n_next;
      rd_n_reg <= rd_n_next;
      ack_n_reg <= ack_n_next;
      a0_reg <= a0_next;
      d_oe_reg <= d_oe_next;
      d_out_reg <= d_out_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
    end
  end

  // pins, read data and done straight from flops; busy decoded from the state
  assign cs_n = cs_n_reg;
  assign wr_n = wr_n_reg;
  assign rd_n = rd_n_reg;
  assign ack_n = ack_n_reg;
  assign a0 = a0_reg;
  assign d_out = d_out_reg;
  assign d_oe = d_oe_reg;
  assign cyc.rdata = rdata_reg;
  assign cyc.done = done_reg;
  assign cyc.busy = (state_reg != S_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wr_needs_select: assert property (!wr_n |-> !cs_n) else $error("write strobe without select");
  a_rd_needs_select: assert property (!rd_n |-> !cs_n) else $error("read strobe without select");
  a_ack_deselected: assert property (!ack_n |-> cs_n && rd_n && wr_n) else $error("ack overlaps a bus cycle");
  a_wr_pulse_width: assert property ($fell(wr_n) |-> (!wr_n)[*6] ##1 wr_n) else $error("write pulse width");
  a_drive_write_only: assert property (d_oe |-> !cs_n && rd_n && ack_n) else $error("bus driven off write");
endmodule // picctl_strobe
`default_nettype wire

//--- picctl_dummy_unused.sv
`timescale 1ns/100ps

//--- picctl_dev_model.sv
// behavioural model of the eight-level interrupt controller device
// assumes the host owns the strobes and the bench resolves the data bus with a pull-up
`timescale 1ns/100ps
`default_nettype none
module picctl_dev_model (
  // strobes from the host
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic ack_n,
  input wire logic a0,
  // data bus
  input wire logic [7:0] d_bus,
  output logic [7:0] d_dev,
  output logic d_dev_oe,
  // interrupt side
  input wire logic [7:0] req_lines,
  output logic int_out
);
  logic [7:0] pending_request_reg = 8'h00;
  logic [7:0] in_service_reg = 8'h00;
  logic [7:0] request_mask_reg = 8'h00;
  logic [7:0] word1 = 8'h00;
  logic [7:0] word2 = 8'h00;
  logic [7:0] req_prev = 8'h00;
  logic [7:0] ack_byte = 8'h00;
  logic [3:0] win = 4'h8;
  logic [2:0] step = 3'h0;
  logic [2:0] lvl = 3'h7;
  logic [2:0] cascade_id_lines = 3'h7;
  logic ptr_mode = 1'b0;
  logic auto_end_of_service = 1'b0;
  logic ack_drive = 1'b0;
  logic in_pulse = 1'b0;
  int npulse = 0;

  // lowest set index wins, 8 when empty
  function automatic logic [3:0] pick(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      if (v[i]) return 4'(i);
    end
    return 4'h8;
  endfunction

  // interrupt only when an unmasked level outranks everything in service
  assign int_out = pick(pending_request_reg & ~request_mask_reg) < pick(in_service_reg);

  // edge mode: a line must be held high until acknowledged
  always @(req_lines) begin
    pending_request_reg = (pending_request_reg | (req_lines & ~req_prev)) & req_lines;
    req_prev = req_lines;
  end

  // command words latch on the trailing write edge
  always @(posedge wr_n) begin
    if (!cs_n) begin
      if (!a0 && d_bus[4]) begin
        word1 = d_bus;
        step = 3'h2;
        request_mask_reg = 8'h00;
        in_service_reg = 8'h00;
        pending_request_reg = 8'h00;
        ptr_mode = 1'b0;
        auto_end_of_service = 1'b0;
      end else if (step == 3'h2) begin
        word2 = d_bus;
        step = !word1[1] ? 3'h3 : (word1[0] ? 3'h4 : 3'h0);
      end else if (step == 3'h3) begin
        step = word1[0] ? 3'h4 : 3'h0;
      end else if (step == 3'h4) begin
        ptr_mode = d_bus[0];
        auto_end_of_service = d_bus[1];
        step = 3'h0;
      end else if (a0) begin
        request_mask_reg = d_bus;
      end
    end
  end

  // first pulse freezes the choice, later pulses only present bytes
  always @(negedge ack_n) begin
    in_pulse = 1'b1;
    if (npulse == 0) begin
      win = pick(pending_request_reg & ~request_mask_reg);
      lvl = win[3] ? 3'h7 : win[2:0];
      if (!win[3]) begin
        in_service_reg[lvl] = 1'b1;
        pending_request_reg[lvl] = 1'b0;
      end
    end
    if (ptr_mode) ack_byte = {word2[7:3], lvl};
    else if (npulse == 0) ack_byte = 8'hcd;
    else if (npulse == 1) ack_byte = word1[2] ? {word1[7:5], lvl, 2'b00} : {word1[7:6], lvl, 3'b000};
    else ack_byte = word2;
    ack_drive = !(ptr_mode && npulse == 0);
  end

  // in_pulse guards against the reset-time rise of the strobe
  always @(posedge ack_n) begin
    if (in_pulse) begin
      in_pulse = 1'b0;
      ack_drive = 1'b0;
      npulse = npulse + 1;
      // master shows the chosen level's id once the first pulse ends
      if (npulse == 1) cascade_id_lines = lvl;
      if (npulse == (ptr_mode ? 2 : 3)) begin
        if (auto_end_of_service) in_service_reg[lvl] = 1'b0;
        npulse = 0;
      end
    end
  end

  // bus driven only for a selected read or a due vector byte
  assign d_dev_oe = (!cs_n && !rd_n) || ack_drive;
  assign d_dev = ack_drive ? ack_byte : (a0 ? request_mask_reg : pending_request_reg);
endmodule // picctl_dev_model
`default_nettype wire

//--- picctl_host_tb.sv
// bench for the interrupt controller host: refusals, init, call and pointer vectors
// assumes the device model on the pins; undriven data bus floats high
`timescale 1ns/100ps
`default_nettype none
module picctl_host_tb;
  import picctl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_addr = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic ack_enable = 1'b0;
  logic [7:0] req_lines = 8'h00;
  logic cmd_ready, cmd_refused, rd_valid, init_done, vec_valid, vec_ptr;
  logic cs_n, wr_n, rd_n, ack_n, a0, d_oe, dev_oe, int_line, refused;
  logic [7:0] rd_data, vec_opcode, d_out, dev_d, d_in, rd;
  logic [15:0] vec_addr;
  logic [7:0] icw1_tab [2] = '{8'hb6, 8'hd2};
  logic [7:0] byte2_tab [2] = '{8'hac, 8'hd8};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #2.5 ref_clk = ~ref_clk;
  // pull-up wins where nobody drives
  assign d_in = d_oe ? d_out : (dev_oe ? dev_d : 8'hff);

  picctl_host picctl_host_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .CMD_REFUSED(cmd_refused),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .INIT_DONE(init_done), .ACK_ENABLE(ack_enable),
    .VEC_VALID(vec_valid), .VEC_POINTER_MODE(vec_ptr), .VEC_OPCODE(vec_opcode), .VEC_ADDR(vec_addr),
    .PIC_CS_N(cs_n), .PIC_WR_N(wr_n), .PIC_RD_N(rd_n), .PIC_CPU_ACK_N(ack_n), .PIC_CMD_ADDR_BIT(a0),
    .PIC_D_IN(d_in), .PIC_D_OUT(d_out), .PIC_D_OE(d_oe), .PIC_INT(int_line));

  picctl_dev_model picctl_dev_model_inst (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n), .a0(a0),
    .d_bus(d_in), .d_dev(dev_d), .d_dev_oe(dev_oe), .req_lines(req_lines), .int_out(int_line));

  task automatic close_out;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one command on the user port, then wait until the host is idle again
  task automatic cmd(input logic w, input logic a, input logic [7:0] d);
    int i;
    refused = 1'b0;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 100) begin
      @(posedge ref_clk) #1;
      i++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    @(posedge ref_clk) #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 40; i++) begin
      if (cmd_refused === 1'b1) refused = 1'b1;
      if (rd_valid === 1'b1) rd = rd_data;
      if (cmd_ready === 1'b1 && i > 0) break;
      @(posedge ref_clk) #1;
    end
  endtask

  // bounded wait for the end of an acknowledge sequence
  task automatic wait_vec;
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk) #1;
      if (vec_valid === 1'b1) break;
    end
    chk(vec_valid, 1'b1);
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out;
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cmd(1'b0, 1'b0, 8'h00);
    chk(refused, 1'b1);
    cmd(1'b1, 1'b1, 8'h10);
    chk(refused, 1'b1);
    chk(init_done, 1'b0);
    // call mode at both intervals, level zero masked so level three wins
    for (int k = 0; k < 2; k++) begin
      cmd(1'b1, 1'b0, icw1_tab[k]);
      cmd(1'b1, 1'b1, 8'h40);
      chk(init_done, 1'b1);
      cmd(1'b1, 1'b1, 8'h01);
      cmd(1'b0, 1'b1, 8'h00);
      chk(rd, 8'h01);
      ack_enable = 1'b1;
      req_lines = 8'h09;
      wait_vec;
      chk(vec_opcode, 8'hcd);
      chk(vec_addr, {8'h40, byte2_tab[k]});
      chk(vec_ptr, 1'b0);
      cmd(1'b0, 1'b0, 8'h00);
      chk(rd, 8'h01);
      req_lines = 8'h00;
    end
    // pointer mode with automatic end of service
    cmd(1'b1, 1'b0, 8'h13);
    cmd(1'b1, 1'b1, 8'h48);
    cmd(1'b1, 1'b1, 8'h03);
    chk(init_done, 1'b1);
    req_lines = 8'h20;
    wait_vec;
    chk(vec_addr, 16'h004d);
    chk(vec_opcode, 8'h00);
    chk(vec_ptr, 1'b1);
    // request gone before the first pulse answers as level seven
    req_lines = 8'h24;
    repeat (2) @(posedge ref_clk) #1;
    req_lines = 8'h20;
    wait_vec;
    chk(vec_addr, 16'h004f);
    // a lower level only gets through if service was cleared
    req_lines = 8'h60;
    wait_vec;
    chk(vec_addr, 16'h004e);
    close_out;
  end
endmodule // picctl_host_tb
`default_nettype wire
